// *** design/osc_pkg.sv ***
// Oscillator start-up configuration package: field layouts, encodings, register map, timing counts.
// Assumes a single 25 MHz clock domain and a plain address/strobe register port.
package osc_pkg;

  // Configuration word field positions
  localparam int SRC_SEL_LSB   = 0;
  localparam int TWO_SPEED_BIT = 7;
  localparam int POSC_MODE_LSB = 0;
  localparam int PIN_FUNC_BIT  = 2;
  localparam int SWMON_LSB     = 6;

  // Initial clock source encodings
  typedef enum logic [2:0] {
    SRC_FRC      = 3'h0,
    SRC_FRC_PLL  = 3'h1,
    SRC_PRI      = 3'h2,
    SRC_PRI_PLL  = 3'h3,
    SRC_SOSC     = 3'h4,
    SRC_LOW_POWER_RC_OSCILLATOR     = 3'h5,
    SRC_FRC_DIV  = 3'h6,
    SRC_FRC_PS   = 3'h7
  } osc_src_e;

  // Primary oscillator mode encodings
  typedef enum logic [1:0] {
    PMODE_EXT  = 2'h0,
    PMODE_XT   = 2'h1,
    PMODE_HS   = 2'h2,
    PMODE_OFF  = 2'h3
  } osc_pmode_e;

  // Decoded configuration
  typedef struct packed {
    logic       two_speed;
    osc_src_e   src;
    logic [1:0] swmon;
    osc_pmode_e pmode;
    logic       pin_func;
  } osc_cfg_s;

  // Register map (byte offsets, 8-bit data in low bits)
  localparam logic [3:0] REG_SRC_CFG   = 4'h0;
  localparam logic [3:0] REG_OSC_CFG   = 4'h4;
  localparam logic [3:0] REG_STATUS    = 4'h8;
  localparam logic [3:0] REG_CTRL      = 4'hC;

  // Reset values of the configuration words (erased state)
  localparam logic [7:0] SRC_CFG_RST = 8'h87;
  localparam logic [7:0] OSC_CFG_RST = 8'hC7;

  // Source ready wait after start
  localparam int CLK_HZ       = 25_000_000;
  localparam int READY_US     = 10;
  localparam int READY_CYCLES = (READY_US * (CLK_HZ / 1_000_000));

endpackage

// *** design/osc_cfg_store.sv ***
// Configuration word store: two small registered words written by the programming path.
// Assumes writes come from the register port of the parent; words survive device reset.
`timescale 1ns/1ps
module osc_cfg_store #(
  parameter int DW = 8
) (
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  // Write side
  input  wire logic          i_we,
  input  wire logic          i_sel,
  input  wire logic [DW-1:0] i_wdata,
  // Read side
  output logic      [DW-1:0] o_word0,
  output logic      [DW-1:0] o_word1
);
  import osc_pkg::*;

  initial begin
    if (DW < 8) $error("osc_cfg_store needs DW of at least 8");
  end

  // Nonvolatile words: erased pattern at power-up, kept across device resets
  logic [DW-1:0] w0_q = DW'(SRC_CFG_RST);
  logic [DW-1:0] w1_q = DW'(OSC_CFG_RST);
  logic [DW-1:0] w0_d, w1_d;

  // Next word values; writes are ignored while reset is held
  always_comb begin
    w0_d = w0_q;
    w1_d = w1_q;
    if (i_we && !i_sel && !i_rst) w0_d = i_wdata;
    if (i_we && i_sel && !i_rst)  w1_d = i_wdata;
  end

  // Word registers, no reset so a pending source choice reaches the next sample
  always_ff @(posedge i_clk) begin
    w0_q <= w0_d;
    w1_q <= w1_d;
  end

  assign o_word0 = w0_q;
  assign o_word1 = w1_q;
endmodule

// *** design/osc_startup.sv ***
// What this block does
// - Two-speed on: run fast RC first, switch to chosen source once ready.
// - Two-speed off: start straight from the chosen source.
// - Three-bit source field selects one of eight clock sources.
// - Source change waits for reset if switching enabled, else applies at once.
// - Switch/monitor field 1x disables both switching and failure monitor.
// - Value 01 switching only; value 00 switching and failure monitor.
// - Two-bit primary mode: off, high-speed crystal, medium crystal, external clock.
// - Pin function 1 drives clock out on second pin, unless crystal mode.
// - Pin function 0 without crystal mode frees the second pin as digital I/O.
//
// Oscillator start-up configuration top: config word store, sampling, source sequencing.
// Assumes synchronous inputs, one 25 MHz clock, and a plain strobed register port.
`timescale 1ns/1ps
module osc_startup #(
  parameter int READY_WAIT = osc_pkg::READY_CYCLES
) (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // Register port
  input  wire logic [3:0]           i_addr,
  input  wire logic [7:0]           i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [7:0]           o_rdata,
  // Oscillator status from analog, GPIO data and enable for the second pin
  input  wire logic                 i_src_ready,
  input  wire logic                 i_clk_fail,
  input  wire logic                 i_gpio_out,
  input  wire logic                 i_gpio_oe,
  // Clock selection
  output osc_pkg::osc_src_e         o_active_src,
  output osc_pkg::osc_pmode_e       o_pmode,
  output logic                      o_switch_en,
  output logic                      o_monitor_en,
  output logic                      o_clk_fail_alarm,
  // Second oscillator pin
  output logic                      o_pin2_clkout,
  output logic                      o_pin2_gpio,
  output logic                      o_pin2_oe
);
  import osc_pkg::*;

  initial begin
    if (READY_WAIT < 1) $error("osc_startup READY_WAIT must be at least 1");
  end

  typedef enum logic [1:0] {ST_SAMPLE, ST_INTERIM, ST_RUN} osc_st_e;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Crystal modes own the second pin
  function automatic logic is_crystal(input osc_pmode_e m);
    return (m == PMODE_XT) || (m == PMODE_HS);
  endfunction

  // Unpack the two configuration words
  function automatic osc_cfg_s decode(input logic [7:0] w0, input logic [7:0] w1);
    osc_cfg_s c;
    c.two_speed = w0[TWO_SPEED_BIT];
    c.src       = osc_src_e'(w0[SRC_SEL_LSB +: 3]);
    c.swmon     = w1[SWMON_LSB +: 2];
    c.pmode     = osc_pmode_e'(w1[POSC_MODE_LSB +: 2]);
    c.pin_func  = w1[PIN_FUNC_BIT];
    return c;
  endfunction

  // ----------------------------------------
  // Configuration word store
  // ----------------------------------------
  logic [7:0] word0, word1;
  logic       cfg_we;
  assign cfg_we = i_wr && ((i_addr == REG_SRC_CFG) || (i_addr == REG_OSC_CFG));

  osc_cfg_store #(.DW(8)) u_store (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_we    (cfg_we),
    .i_sel   (i_addr == REG_OSC_CFG),
    .i_wdata (i_wdata),
    .o_word0 (word0),
    .o_word1 (word1)
  );

  osc_cfg_s live;
  assign live = decode(word0, word1);

  // ----------------------------------------
  // Sequencing state
  // ----------------------------------------
  osc_st_e    st_q, st_d;
  osc_cfg_s   cfg_q, cfg_d;
  osc_src_e   act_q, act_d;
  logic [$clog2(READY_WAIT+1)-1:0] wait_q, wait_d;
  logic       fail_q, fail_d;

  // Next state of sampling, start-up and source selection
  always_comb begin
    st_d   = st_q;
    cfg_d  = cfg_q;
    act_d  = act_q;
    wait_d = wait_q;
    fail_d = fail_q;
    unique case (st_q)
      ST_SAMPLE: begin
        cfg_d = live;
        if (live.two_speed) begin
          act_d = SRC_FRC;
          st_d  = ST_INTERIM;
        end else begin
          act_d = live.src;
          st_d  = ST_RUN;
        end
        wait_d = '0;
      end
      ST_INTERIM: begin
        if (i_src_ready) begin
          if (wait_q == ($bits(wait_q))'(READY_WAIT - 1)) begin
            act_d = cfg_q.src;
            st_d  = ST_RUN;
          end else begin
            wait_d = wait_q + 1'b1;
          end
        end else begin
          wait_d = '0;
        end
      end
      ST_RUN: begin
        // Switching disabled: new source field takes effect at once
        if (cfg_q.swmon[1]) begin
          cfg_d.src = live.src;
          act_d     = live.src;
        end
        // Switching enabled: hold sampled field until next reset
      end
    endcase
    // Failure monitor only when field is 00
    if (st_q == ST_RUN && !cfg_q.swmon[1] && !cfg_q.swmon[0] && i_clk_fail) begin
      fail_d = 1'b1;
    end
    // Other fields apply immediately
    if (st_q != ST_SAMPLE) begin
      cfg_d.two_speed = live.two_speed;
      cfg_d.swmon     = live.swmon;
      cfg_d.pmode     = live.pmode;
      cfg_d.pin_func  = live.pin_func;
    end
  end

  // Sequencing registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q   <= ST_SAMPLE;
      cfg_q  <= '0;
      act_q  <= SRC_FRC;
      wait_q <= '0;
      fail_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cfg_q  <= cfg_d;
      act_q  <= act_d;
      wait_q <= wait_d;
      fail_q <= fail_d;
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  osc_src_e   src_out_q;
  osc_pmode_e pm_q;
  logic       sw_q, mon_q, ck_q, gp_q, oe_q;
  logic       sw_d, mon_d, ck_d, gp_d, oe_d;

  // Decode switching, monitor and pin function
  always_comb begin
    sw_d  = !cfg_d.swmon[1];
    mon_d = (cfg_d.swmon == 2'h0);
    ck_d  = 1'b0;
    gp_d  = 1'b0;
    oe_d  = 1'b0;
    if (!is_crystal(cfg_d.pmode)) begin
      if (cfg_d.pin_func) begin
        ck_d = 1'b1;
        oe_d = 1'b1;
      end else begin
        gp_d = i_gpio_out;
        oe_d = i_gpio_oe;
      end
    end
  end

  // Output flops
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      src_out_q <= SRC_FRC;
      pm_q      <= PMODE_OFF;
      sw_q      <= 1'b0;
      mon_q     <= 1'b0;
      ck_q      <= 1'b0;
      gp_q      <= 1'b0;
      oe_q      <= 1'b0;
    end else begin
      src_out_q <= act_d;
      pm_q      <= cfg_d.pmode;
      sw_q      <= sw_d;
      mon_q     <= mon_d;
      ck_q      <= ck_d;
      gp_q      <= gp_d;
      oe_q      <= oe_d;
    end
  end

  assign o_active_src     = src_out_q;
  assign o_pmode          = pm_q;
  assign o_switch_en      = sw_q;
  assign o_monitor_en     = mon_q;
  assign o_clk_fail_alarm = fail_q;
  assign o_pin2_clkout    = ck_q;
  assign o_pin2_gpio      = gp_q;
  assign o_pin2_oe        = oe_q;

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  logic [7:0] rd_q, rd_d;

  // Read mux, unmapped reads return zero
  always_comb begin
    rd_d = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        REG_SRC_CFG: rd_d = word0;
        REG_OSC_CFG: rd_d = word1;
        REG_STATUS:  rd_d = {fail_q, st_q == ST_RUN, sw_q, mon_q, 1'b0, act_q};
        REG_CTRL:    rd_d = {5'h00, cfg_q.src};
        default:     rd_d = 8'h00;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_q <= 8'h00;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign o_rdata = rd_q;
endmodule

// *** testbench/osc_startup_monitor.sv ***
// Checker for the oscillator start-up block, bound to its top module.
// Assumes the design package is compiled first.
`timescale 1ns/1ps
module osc_startup_monitor (
  // Clock, reset and register port
  input wire logic                i_clk,
  input wire logic                i_rst,
  input wire logic [3:0]          i_addr,
  input wire logic                i_wr,
  input wire logic                i_rd,
  input wire logic [7:0]          o_rdata,
  // Status and selection
  input wire logic                i_clk_fail,
  input wire osc_pkg::osc_src_e   o_active_src,
  input wire osc_pkg::osc_pmode_e o_pmode,
  input wire logic                o_switch_en,
  input wire logic                o_monitor_en,
  input wire logic                o_clk_fail_alarm,
  input wire logic                o_pin2_clkout,
  input wire logic                o_pin2_oe
);
  import osc_pkg::*;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  mon_needs_sw_a: assert property (o_monitor_en |-> o_switch_en)
    else $error("monitor on without switching");
  xtal_pin_off_a: assert property ((o_pmode inside {PMODE_XT, PMODE_HS}) && $stable(o_pmode)
    |-> !o_pin2_oe && !o_pin2_clkout) else $error("pin driven in crystal mode");
  clkout_drive_a: assert property (o_pin2_clkout |-> o_pin2_oe)
    else $error("clock out without drive");
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read slot");
  status_read_a: assert property ($past(i_rd && i_addr == REG_STATUS) |->
    o_rdata[5:0] == {$past(o_switch_en), $past(o_monitor_en), 1'b0, $past(o_active_src)}
    && o_rdata[7] == $past(o_clk_fail_alarm)) else $error("status read wrong");
  alarm_sticky_a: assert property (o_clk_fail_alarm |=> o_clk_fail_alarm)
    else $error("alarm cleared without reset");
  alarm_cause_a: assert property ($rose(o_clk_fail_alarm) |->
    $past(i_clk_fail) && $past(o_monitor_en)) else $error("alarm without monitored failure");
  cfg_hold_a: assert property ($changed(o_pmode) |-> $past(i_wr) || $past(i_wr, 2)
    || $past(i_rst, 2) || $past(i_rst, 3)) else $error("mode changed without cause");
endmodule

bind osc_startup osc_startup_monitor u_mon (.i_clk, .i_rst, .i_addr, .i_wr, .i_rd, .o_rdata,
  .i_clk_fail, .o_active_src, .o_pmode, .o_switch_en, .o_monitor_en, .o_clk_fail_alarm,
  .o_pin2_clkout, .o_pin2_oe);

// *** testbench/osc_src_model.sv ***
// Model of the external oscillator: ready after start-up, failure on command.
// Assumes the bench clock and the block's active-high reset.
`timescale 1ns/1ps
module osc_src_model #(
  parameter int START = 6
) (
  // Clock, reset and command
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_fail_cmd,
  // Oscillator status
  output logic      o_ready,
  output logic      o_fail
);
  logic [3:0] cnt_q;
  // Start-up count; a failed oscillator is never ready
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 4'h0;
    end else if (cnt_q != 4'(START)) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  assign o_ready = (cnt_q == 4'(START)) && !i_fail_cmd;
  assign o_fail  = i_fail_cmd;
endmodule

// *** testbench/tb_osc_startup.sv ***
// Self-checking bench for the oscillator start-up block.
// Assumes the package, design, checker and oscillator model are compiled first.
`timescale 1ns/1ps
module tb_osc_startup;
  import osc_pkg::*;
  logic       i_clk, i_rst, i_wr, i_rd, i_gpio_out, i_gpio_oe, fail_cmd, rdy, fl;
  logic       o_switch_en, o_monitor_en, o_clk_fail_alarm, o_pin2_clkout, o_pin2_gpio, o_pin2_oe;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata;
  osc_src_e   o_active_src;
  osc_pmode_e o_pmode;
  int         n_mismatch, checks, cyc_n;
  // ----------------------------------------
  // Instances and clock
  // ----------------------------------------
  osc_startup #(.READY_WAIT(4)) DUT (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_src_ready(rdy), .i_clk_fail(fl), .i_gpio_out, .i_gpio_oe, .o_active_src, .o_pmode,
    .o_switch_en, .o_monitor_en, .o_clk_fail_alarm, .o_pin2_clkout, .o_pin2_gpio, .o_pin2_oe);
  osc_src_model u_osc (.i_clk, .i_rst, .i_fail_cmd(fail_cmd), .o_ready(rdy), .o_fail(fl));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // Hang guard
  always @(posedge i_clk) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      n_mismatch++;
      results();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  task automatic t_start();
    logic [7:0] v;
    @(posedge i_clk);
    i_rst <= 1'b1;
    cyc(3);
    i_rst <= 1'b0;
    cyc(2);
    chk(8'(o_active_src), 8'(SRC_FRC));
    chk(8'(o_clk_fail_alarm), 8'h00);
    rd(REG_SRC_CFG, v);
    chk(v, SRC_CFG_RST);
    rd(REG_OSC_CFG, v);
    chk(v, OSC_CFG_RST);
    cyc(20);
    chk(8'(o_active_src), 8'(SRC_FRC_PS));
  endtask
  task automatic t_src();
    for (int k = 0; k < 8; k++) begin
      wr(REG_SRC_CFG, {5'h00, 3'(k)});
      cyc(3);
      chk(8'(o_active_src), 8'(k));
    end
  endtask
  task automatic t_pins();
    logic x;
    for (int m = 0; m < 4; m++) begin
      for (int p = 0; p < 2; p++) begin
        x = (m == 1) || (m == 2);
        wr(REG_OSC_CFG, {5'h18, 1'(p), 2'(m)});
        cyc(3);
        chk(8'(o_pmode), 8'(m));
        chk(8'(o_pin2_clkout), 8'(!x && p == 1));
        chk(8'(o_pin2_oe), 8'(!x));
        if (!x && p == 0) chk(8'(o_pin2_gpio), 8'h01);
      end
    end
  endtask
  task automatic t_swmon();
    logic [7:0] v;
    for (int s = 3; s >= 0; s--) begin
      wr(REG_OSC_CFG, {2'(s), 6'h07});
      cyc(3);
      chk({6'h00, o_switch_en, o_monitor_en}, (s > 1) ? 8'h00 : (s == 1) ? 8'h02 : 8'h03);
    end
    wr(REG_SRC_CFG, 8'h02);
    cyc(3);
    chk(8'(o_active_src), 8'(SRC_FRC_PS));
    fail_cmd <= 1'b1;
    cyc(3);
    fail_cmd <= 1'b0;
    wr(REG_STATUS, 8'h00);
    rd(REG_STATUS, v);
    chk(v, 8'hF7);
    rd(4'h2, v);
    chk(v, 8'h00);
    wr(REG_OSC_CFG, 8'hC7);
    cyc(3);
    chk({6'h00, o_clk_fail_alarm, o_monitor_en}, 8'h02);
  endtask
  task automatic t_restart();
    logic [7:0] v;
    @(posedge i_clk);
    i_rst <= 1'b1;
    cyc(3);
    i_rst <= 1'b0;
    cyc(2);
    chk(8'(o_active_src), 8'(SRC_PRI));
    chk(8'(o_clk_fail_alarm), 8'h00);
    rd(REG_SRC_CFG, v);
    chk(v, 8'h02);
    cyc(20);
    chk(8'(o_active_src), 8'(SRC_PRI));
  endtask
  task automatic results();
    if (n_mismatch == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Main sequence, ending with a second reset in mid-run
  initial begin
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_gpio_out = 1'b1;
    i_gpio_oe = 1'b1;
    fail_cmd = 1'b0;
    n_mismatch = 0;
    checks = 0;
    cyc_n = 0;
    t_start();
    t_src();
    t_pins();
    t_swmon();
    t_restart();
    results();
  end
endmodule
